// >>> logic/duc_defines.svh
// Offsets, field positions, reset values and timing counts of the DAC update control
`ifndef DUC_DEFINES_SVH
`define DUC_DEFINES_SVH

// Serial word mode field
`define DUC_MODE_SPECIAL    2'h0
`define DUC_MODE_GAIN       2'h1
`define DUC_MODE_OFFSET     2'h2
`define DUC_MODE_INPUT      2'h3

// Special function codes
`define DUC_SF_CONTROL      6'h01
`define DUC_SF_PROBE        6'h0a
`define DUC_SF_SEL_LO       6'h0b
`define DUC_SF_SEL_HI       6'h0c
`define DUC_SF_GPIO         6'h0d

// Control register fields
`define DUC_CTL_PDOWN       0
`define DUC_CTL_TSD_EN      1
`define DUC_CTL_AB          2
`define DUC_CTL_TSD_FLAG    4

// Probe register fields
`define DUC_PRB_EN          5
`define DUC_PRB_IN0         5'h10
`define DUC_PRB_IN1         5'h11

// General pin register fields
`define DUC_GP_DIR          1
`define DUC_GP_LVL          0

// Reset values and mid scale
`define DUC_RST_INPUT       16'h8000
`define DUC_RST_GAIN        16'hffff
`define DUC_RST_OFFSET      16'h8000
`define DUC_MID_SCALE       19'h08000
`define DUC_RST_PINS        5'h05

// Timing
`define DUC_CLK_NS          25
`define DUC_STAGE_NS        600
`define DUC_FINAL_NS        300
`define DUC_STAGE_CYC       ((`DUC_STAGE_NS + `DUC_CLK_NS - 1) / `DUC_CLK_NS)
`define DUC_TAIL_CYC        ((`DUC_STAGE_NS + `DUC_FINAL_NS + `DUC_CLK_NS - 1) / `DUC_CLK_NS)

`endif

// >>> logic/duc_pkg.sv
// Types shared by the DAC update control
package duc_pkg;
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_CALC = 3'b010,
        ENG_TAIL = 3'b100
    } duc_eng_e;
    typedef logic [15:0] duc_word_t;
endpackage : duc_pkg

// >>> logic/duc_update_ctrl.sv
// DAC update control: recalculation engine, busy line, load, probe, pin and shutdown
`timescale 1ns/10ps
`default_nettype none
`include "duc_defines.svh"

module duc_update_ctrl
    import duc_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         wr_stb_in,
    input  wire logic [1:0]   wr_mode_in,
    input  wire logic [5:0]   wr_addr_in,
    input  wire logic [15:0]  wr_data_in,
    input  wire logic         rd_stb_in,
    input  wire logic [5:0]   rd_code_in,
    output logic      [15:0]  rd_data_out,
    output logic              rd_valid_out,
    input  wire logic         load_outputs_strobe_b_in,
    input  wire logic         data_format_select_in,
    input  wire logic         busy_b_in,
    output logic              busy_b_out,
    output logic              busy_b_oe_out,
    input  wire logic         over_temp_in,
    input  wire logic         gpio_in,
    output logic              gpio_out,
    output logic              gpio_oe_out,
    output logic              probe_output_oe_out,
    output logic      [9:0]   probe_route_out,
    output logic      [127:0] dac_data_out,
    output logic              dac_off_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    logic       rst_b;
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;

    // Reset released through two flops
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // Pins: strobe, format, busy sense, over-temperature, general pin
    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_r <= `DUC_RST_PINS;
            pin_sync_r <= `DUC_RST_PINS;
        end else begin
            pin_meta_r <= {gpio_in, over_temp_in, busy_b_in, data_format_select_in,
                           load_outputs_strobe_b_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    logic load_outputs_strobe_b;
    logic fmt_twos;
    logic busy_sense_b;
    logic over_temp;
    logic gpio_lvl;
    assign load_outputs_strobe_b       = pin_sync_r[0];
    assign fmt_twos     = pin_sync_r[1];
    assign busy_sense_b = pin_sync_r[2];
    assign over_temp    = pin_sync_r[3];
    assign gpio_lvl     = pin_sync_r[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode
    function automatic logic [7:0] chan_mask(input logic [5:0] a);
        logic [7:0] m;
        m = 8'h00;
        if (!a[5]) begin
            case (a[4:3])
                2'h0: begin
                    case (a[2:0])
                        3'h0:    m = 8'hff;
                        3'h1:    m = 8'h0f;
                        3'h2:    m = 8'hf0;
                        default: m = 8'h00;
                    endcase
                end
                2'h1:    m = a[2] ? 8'h00 : (8'h01 << a[1:0]);
                2'h2:    m = a[2] ? 8'h00 : (8'h10 << a[1:0]);
                default: m = 8'h00;
            endcase
        end
        return m;
    endfunction : chan_mask

    function automatic logic [3:0] first_set(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : first_set

    logic [2:0]  ctrl_r;
    logic [2:0]  ctrl_nxt;
    logic        shut_r;
    logic        shut_nxt;
    logic [7:0]  sel_r;
    logic [7:0]  sel_nxt;
    logic [5:0]  probe_r;
    logic [5:0]  probe_nxt;
    logic [1:0]  gpcfg_r;
    logic [1:0]  gpcfg_nxt;
    logic [4:0]  selcnt_r;
    logic [4:0]  selcnt_nxt;
    logic        wr_chan;
    logic        wr_spec;
    logic [7:0]  wmask;
    logic [15:0] new_pend;

    assign wr_chan  = wr_stb_in && (wr_mode_in != `DUC_MODE_SPECIAL);
    assign wr_spec  = wr_stb_in && (wr_mode_in == `DUC_MODE_SPECIAL);
    assign wmask    = wr_chan ? chan_mask(wr_addr_in) : 8'h00;
    // A or B half picked by the A/B bit for every channel write
    assign new_pend = ctrl_r[`DUC_CTL_AB] ? {wmask, 8'h00} : {8'h00, wmask};

    // Special registers, select-write busy timer and thermal latch
    always_comb begin
        ctrl_nxt   = ctrl_r;
        sel_nxt    = sel_r;
        probe_nxt  = probe_r;
        gpcfg_nxt  = gpcfg_r;
        selcnt_nxt = (selcnt_r != 5'h00) ? selcnt_r - 5'h01 : 5'h00;
        if (wr_spec) begin
            unique case (wr_addr_in)
                `DUC_SF_CONTROL: ctrl_nxt  = wr_data_in[2:0];
                `DUC_SF_PROBE:   probe_nxt = wr_data_in[5:0];
                `DUC_SF_GPIO:    gpcfg_nxt = wr_data_in[1:0];
                `DUC_SF_SEL_LO: begin
                    sel_nxt[3:0] = wr_data_in[3:0];
                    selcnt_nxt   = 5'(`DUC_STAGE_CYC);
                end
                `DUC_SF_SEL_HI: begin
                    sel_nxt[7:4] = wr_data_in[3:0];
                    selcnt_nxt   = 5'(`DUC_STAGE_CYC);
                end
                default: ;
            endcase
        end
        // Latched until enable cleared
        shut_nxt = ctrl_nxt[`DUC_CTL_TSD_EN] && (shut_r || over_temp);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Recalculation engine, one shared multiplier
    duc_eng_e             state_r;
    duc_eng_e             state_nxt;
    logic [5:0]           cnt_r;
    logic [5:0]           cnt_nxt;
    logic [3:0]           cur_r;
    logic [3:0]           cur_nxt;
    logic [15:0]          pend_r;
    logic [15:0]          pend_nxt;
    logic [15:0]          pend_clr;
    logic                 calc_done;
    logic [7:0][15:0]     x1a_q;
    logic [7:0][15:0]     x1b_q;
    logic [7:0][15:0]     gain_q;
    logic [7:0][15:0]     offs_q;
    duc_word_t            xu;
    duc_word_t            cu;
    logic [16:0]          gain_p1;
    logic [32:0]          prod;
    logic [18:0]          sum;
    duc_word_t            result;

    // Corrected level: x * (m + 1) / 2^16 + c - mid scale, clamped
    always_comb begin
        xu      = (cur_r[3] ? x1b_q[cur_r[2:0]] : x1a_q[cur_r[2:0]]) ^ {fmt_twos, 15'h0000};
        cu      = offs_q[cur_r[2:0]] ^ {fmt_twos, 15'h0000};
        gain_p1 = {1'b0, gain_q[cur_r[2:0]]} + 17'h00001;
        prod    = 33'(xu) * 33'(gain_p1);
        sum     = {2'b00, prod[32:16]} + {3'b000, cu} - `DUC_MID_SCALE;
        if (sum[18]) begin
            result = 16'h0000;
        end else if (|sum[17:16]) begin
            result = 16'hffff;
        end else begin
            result = sum[15:0];
        end
    end

    // One stage slot per pending level, then the final stages
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        cur_nxt   = cur_r;
        calc_done = 1'b0;
        pend_clr  = 16'h0000;
        unique case (state_r)
            ENG_IDLE: begin
                if (|pend_r) begin
                    state_nxt = ENG_CALC;
                    cur_nxt   = first_set(pend_r);
                    cnt_nxt   = 6'(`DUC_STAGE_CYC - 2);
                end
            end
            ENG_CALC: begin
                if (cnt_r == 6'h00) begin
                    calc_done = 1'b1;
                    pend_clr  = 16'h0001 << cur_r;
                    if (|(pend_r & ~pend_clr)) begin
                        cur_nxt = first_set(pend_r & ~pend_clr);
                        cnt_nxt = 6'(`DUC_STAGE_CYC - 1);
                    end else begin
                        state_nxt = ENG_TAIL;
                        cnt_nxt   = 6'(`DUC_TAIL_CYC - 1);
                    end
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            ENG_TAIL: begin
                if (|pend_r) begin
                    state_nxt = ENG_CALC;
                    cur_nxt   = first_set(pend_r);
                    cnt_nxt   = 6'(`DUC_STAGE_CYC - 1);
                end else if (cnt_r == 6'h00) begin
                    state_nxt = ENG_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
        endcase
        // A new request beats the clear of the same level
        pend_nxt = (pend_r & ~pend_clr) | new_pend;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Busy line and load strobe
    logic own_busy;
    logic busy_oe_r;
    logic line_busy;
    logic line_busy_r;
    logic load_outputs_strobe_prev_r;
    logic load_outputs_strobe_pend_r;
    logic load_outputs_strobe_pend_nxt;
    logic load_outputs_strobe_fall;
    logic busy_rise;
    logic load_fire;

    assign own_busy  = (|pend_r) || (state_r != ENG_IDLE) || (selcnt_r != 5'h00);
    assign line_busy = busy_oe_r || !busy_sense_b;
    assign load_outputs_strobe_fall = load_outputs_strobe_prev_r && !load_outputs_strobe_b;
    assign busy_rise = line_busy_r && !line_busy;
    // Loads only while the shared line is high
    assign load_fire = !line_busy && (load_outputs_strobe_pend_r || load_outputs_strobe_fall
                                      || (busy_rise && !load_outputs_strobe_b));
    assign load_outputs_strobe_pend_nxt = line_busy && (load_outputs_strobe_pend_r || load_outputs_strobe_fall);
    assign busy_b_out    = 1'b0;
    assign busy_b_oe_out = busy_oe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel storage
    for (genvar g = 0; g < 8; g++) begin : g_ch
        duc_word_t x1a_r, x1a_nxt, x1b_r, x1b_nxt, gain_r, gain_nxt, offs_r, offs_nxt;
        duc_word_t ca_r, ca_nxt, cb_r, cb_nxt, dac_r, dac_nxt;
        logic      dirty_r, dirty_nxt;
        logic      hit;

        always_comb begin
            hit      = calc_done && (cur_r[2:0] == 3'(g));
            x1a_nxt  = x1a_r;
            x1b_nxt  = x1b_r;
            gain_nxt = gain_r;
            offs_nxt = offs_r;
            ca_nxt   = (hit && !cur_r[3]) ? result : ca_r;
            cb_nxt   = (hit && cur_r[3]) ? result : cb_r;
            if (wmask[g]) begin
                unique case (wr_mode_in)
                    `DUC_MODE_GAIN:   gain_nxt = wr_data_in;
                    `DUC_MODE_OFFSET: offs_nxt = wr_data_in;
                    `DUC_MODE_INPUT: begin
                        if (ctrl_r[`DUC_CTL_AB]) begin
                            x1b_nxt = wr_data_in;
                        end else begin
                            x1a_nxt = wr_data_in;
                        end
                    end
                    default: ;
                endcase
            end
            // Only rewritten channels load; new result beats load clear
            dirty_nxt = (dirty_r && !load_fire) || hit;
            dac_nxt   = dac_r;
            if (load_fire && dirty_r) begin
                dac_nxt = sel_r[g] ? cb_r : ca_r;
            end
        end

        always_ff @(posedge core_clk_in or negedge rst_b) begin
            if (!rst_b) begin
                x1a_r   <= `DUC_RST_INPUT;
                x1b_r   <= `DUC_RST_INPUT;
                gain_r  <= `DUC_RST_GAIN;
                offs_r  <= `DUC_RST_OFFSET;
                ca_r    <= `DUC_RST_INPUT;
                cb_r    <= `DUC_RST_INPUT;
                dac_r   <= `DUC_RST_INPUT;
                dirty_r <= 1'b0;
            end else begin
                x1a_r   <= x1a_nxt;
                x1b_r   <= x1b_nxt;
                gain_r  <= gain_nxt;
                offs_r  <= offs_nxt;
                ca_r    <= ca_nxt;
                cb_r    <= cb_nxt;
                dac_r   <= dac_nxt;
                dirty_r <= dirty_nxt;
            end
        end

        assign x1a_q[g]    = x1a_r;
        assign x1b_q[g]    = x1b_r;
        assign gain_q[g]   = gain_r;
        assign offs_q[g]   = offs_r;
        assign dac_data_out[16*g +: 16] = dac_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Probe routing, readback and output registers
    logic [9:0]  route_nxt;
    logic [9:0]  route_r;
    logic [15:0] rd_nxt;
    logic [15:0] rd_r;
    logic        rd_valid_r;
    logic        dac_off_r;
    logic        probe_oe_r;
    logic        probe_oe_nxt;

    always_comb begin
        route_nxt = 10'h000;
        // Enable moves with the route so both change at one edge
        probe_oe_nxt = probe_r[`DUC_PRB_EN];
        if (probe_r[`DUC_PRB_EN]) begin
            if (probe_r[4:2] == 3'h0) begin
                route_nxt = 10'h001 << probe_r[1:0];
            end else if (probe_r[4:2] == 3'h2) begin
                route_nxt = 10'h010 << probe_r[1:0];
            end else if (probe_r[4:0] == `DUC_PRB_IN0) begin
                route_nxt = 10'h100;
            end else if (probe_r[4:0] == `DUC_PRB_IN1) begin
                route_nxt = 10'h200;
            end
        end
        unique case (rd_code_in)
            `DUC_SF_CONTROL: rd_nxt = {11'h000, shut_r, 1'b0, ctrl_r};
            `DUC_SF_PROBE:   rd_nxt = {10'h000, probe_r};
            `DUC_SF_SEL_LO:  rd_nxt = {12'h000, sel_r[3:0]};
            `DUC_SF_SEL_HI:  rd_nxt = {12'h000, sel_r[7:4]};
            `DUC_SF_GPIO:    rd_nxt = {15'h0000, gpio_lvl};
            default:         rd_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r      <= 3'h0;
            shut_r      <= 1'b0;
            sel_r       <= 8'h00;
            probe_r     <= 6'h00;
            gpcfg_r     <= 2'h0;
            selcnt_r    <= 5'h00;
            state_r     <= ENG_IDLE;
            cnt_r       <= 6'h00;
            cur_r       <= 4'h0;
            pend_r      <= 16'h0000;
            busy_oe_r   <= 1'b0;
            line_busy_r <= 1'b0;
            load_outputs_strobe_prev_r <= 1'b1;
            load_outputs_strobe_pend_r <= 1'b0;
            route_r     <= 10'h000;
            probe_oe_r  <= 1'b0;
            rd_r        <= 16'h0000;
            rd_valid_r  <= 1'b0;
            dac_off_r   <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            shut_r      <= shut_nxt;
            sel_r       <= sel_nxt;
            probe_r     <= probe_nxt;
            gpcfg_r     <= gpcfg_nxt;
            selcnt_r    <= selcnt_nxt;
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            cur_r       <= cur_nxt;
            pend_r      <= pend_nxt;
            busy_oe_r   <= own_busy;
            line_busy_r <= line_busy;
            load_outputs_strobe_prev_r <= load_outputs_strobe_b;
            load_outputs_strobe_pend_r <= load_outputs_strobe_pend_nxt;
            route_r     <= route_nxt;
            probe_oe_r  <= probe_oe_nxt;
            rd_r        <= rd_nxt;
            rd_valid_r  <= rd_stb_in;
            dac_off_r   <= ctrl_r[`DUC_CTL_PDOWN] || shut_r;
        end
    end

    assign gpio_oe_out         = gpcfg_r[`DUC_GP_DIR];
    assign gpio_out            = gpcfg_r[`DUC_GP_LVL];
    assign probe_output_oe_out = probe_oe_r;
    assign probe_route_out     = route_r;
    assign rd_data_out         = rd_r;
    assign rd_valid_out        = rd_valid_r;
    assign dac_off_out         = dac_off_r;

endmodule : duc_update_ctrl
`default_nettype wire

// >>> tb/duc_update_ctrl_checker.sv
// Port-level assertions for the DAC update control
`timescale 1ns/10ps
`default_nettype none
module duc_update_ctrl_checker (
    input wire logic         core_clk_in,
    input wire logic         rst_b_in,
    input wire logic         wr_stb_in,
    input wire logic [1:0]   wr_mode_in,
    input wire logic [5:0]   wr_addr_in,
    input wire logic         rd_stb_in,
    input wire logic [5:0]   rd_code_in,
    input wire logic [15:0]  rd_data_out,
    input wire logic         rd_valid_out,
    input wire logic         busy_b_in,
    input wire logic         busy_b_out,
    input wire logic         busy_b_oe_out,
    input wire logic         probe_output_oe_out,
    input wire logic [9:0]   probe_route_out,
    input wire logic [127:0] dac_data_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [8:0] busy_cnt_r;
    logic [8:0] busy_cnt_nxt;
    //////////////////////////////////////////////////////////////
    // Cycles the busy drive has stood
    always_comb busy_cnt_nxt = busy_b_oe_out ? busy_cnt_r + 9'h1 : 9'h0;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) busy_cnt_r <= 9'h0;
        else busy_cnt_r <= busy_cnt_nxt;
    end
    // Write steps that raise the busy drive
    sequence chan_wr_s;
        wr_stb_in && wr_mode_in != 2'h0 && wr_addr_in == 6'h08;
    endsequence
    sequence sel_wr_s;
        wr_stb_in && wr_mode_in == 2'h0 && wr_addr_in inside {6'h0b, 6'h0c};
    endsequence
    busy_start_a: assert property (chan_wr_s |-> ##2 busy_b_oe_out)
        else $error("busy missing after channel write");
    select_busy_a: assert property (sel_wr_s |-> ##[1:2] busy_b_oe_out)
        else $error("busy missing after select write");
    busy_min_a: assert property ($fell(busy_b_oe_out) |-> busy_cnt_r >= 9'h18)
        else $error("busy pulse too short");
    dac_freeze_a: assert property (busy_b_oe_out && $past(busy_b_oe_out) |-> $stable(dac_data_out))
        else $error("outputs changed while busy");
    dac_freed_a: assert property (!$stable(dac_data_out) |-> $past(busy_b_in, 2) && !busy_b_oe_out)
        else $error("outputs changed while line low");
    busy_drive_a: assert property (busy_b_oe_out |-> !busy_b_out)
        else $error("busy drive not low");
    probe_off_a: assert property (!probe_output_oe_out |-> probe_route_out == 10'h0)
        else $error("probe routed while disabled");
    probe_route_a: assert property (probe_output_oe_out |-> $onehot0(probe_route_out))
        else $error("probe route not one-hot");
    pin_read_a: assert property (rd_stb_in && rd_code_in == 6'h0d |=> rd_valid_out && rd_data_out[15:1] == 15'h0)
        else $error("pin readback upper bits set");
endmodule : duc_update_ctrl_checker
`default_nettype wire

// >>> tb/duc_peer_model.sv
// Second device sharing the open-drain busy wire
`timescale 1ns/10ps
`default_nettype none
module duc_peer_model (
    input  wire logic hold_in,
    input  wire logic dut_oe_in,
    output logic      line_b_out
);
    // Wired low by either party, weak pull-up otherwise
    assign line_b_out = !(hold_in || dut_oe_in);
endmodule : duc_peer_model
`default_nettype wire

// >>> tb/duc_update_ctrl_tb_top.sv
// Self-checking bench for the DAC update control
`timescale 1ns/10ps
`default_nettype none
module duc_update_ctrl_tb_top;
    logic         core_clk_in = 1'b0;
    logic         rst_b_in, wr_stb_in, rd_stb_in, rd_valid_out, load_outputs_strobe_b_in;
    logic         data_format_select_in, busy_b_in, busy_b_out, busy_b_oe_out, over_temp_in;
    logic         gpio_in, gpio_out, gpio_oe_out, gpio_ext, probe_output_oe_out, dac_off_out;
    logic         peer_hold;
    logic [1:0]   wr_mode_in;
    logic [5:0]   wr_addr_in, rd_code_in;
    logic [15:0]  wr_data_in, rd_data_out;
    logic [9:0]   probe_route_out;
    logic [127:0] dac_data_out;
    int           n_errors = 0;
    int           tests_run = 0;
    //////////////////////////////////////////////////////////////
    // Design, shared busy wire and general pin wire
    duc_update_ctrl duc_update_ctrl_i (.*);
    duc_peer_model duc_peer_model_i (.hold_in(peer_hold), .dut_oe_in(busy_b_oe_out), .line_b_out(busy_b_in));
    assign gpio_in = gpio_oe_out ? gpio_out : gpio_ext;
    initial forever #12.5 core_clk_in = ~core_clk_in;
    // Shared helpers
    function automatic logic [15:0] ch(input int n);
        return dac_data_out[16*n +: 16];
    endfunction : ch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc
    task automatic wr(input logic [1:0] m, input logic [5:0] a, input logic [15:0] d);
        cyc(1);
        {wr_stb_in, wr_mode_in, wr_addr_in, wr_data_in} = {1'b1, m, a, d};
        cyc(1);
        wr_stb_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] c, input logic [15:0] exp);
        cyc(1);
        {rd_stb_in, rd_code_in} = {1'b1, c};
        cyc(1);
        rd_stb_in = 1'b0;
        chk({15'h0, rd_valid_out}, 16'h1);
        chk(rd_data_out, exp);
    endtask : rd
    // Measures the busy drive; an overrun ends the run
    task automatic busy_len(input logic [15:0] exp);
        int n;
        n = 0;
        for (int i = 0; i < 8 && !busy_b_oe_out; i++) cyc(1);
        for (int i = 0; i < 400 && busy_b_oe_out; i++) begin
            cyc(1);
            n++;
        end
        chk(16'(n), exp);
        if (busy_b_oe_out || n == 0) begin
            n_errors++;
            stop_test();
        end
    endtask : busy_len
    task automatic load_pulse();
        cyc(1);
        load_outputs_strobe_b_in = 1'b0;
        cyc(4);
        load_outputs_strobe_b_in = 1'b1;
    endtask : load_pulse
    task automatic settle();
        cyc(2);
        for (int i = 0; i < 400 && !busy_b_in; i++) cyc(1);
        if (!busy_b_in) begin
            n_errors++;
            stop_test();
        end
        cyc(8);
    endtask : settle
    //////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_b_in, wr_stb_in, rd_stb_in, data_format_select_in, over_temp_in} = 5'h0;
        {wr_mode_in, wr_addr_in, wr_data_in, rd_code_in} = 30'h0;
        {load_outputs_strobe_b_in, gpio_ext, peer_hold} = 3'h6;
        cyc(5);
        rst_b_in = 1'b1;
        cyc(4);
        rd(6'h01, 16'h0000);
        rd(6'h3f, 16'h0000);
        chk(ch(7), 16'h8000);
        wr(2'h3, 6'h08, 16'h1234);
        busy_len(16'h003c);
        load_pulse();
        settle();
        chk(ch(0), 16'h1234);
        chk(ch(1), 16'h8000);
        $display("test single channel done");
        wr(2'h3, 6'h00, 16'h0100);
        busy_len(16'h00e4);
        load_pulse();
        settle();
        for (int i = 0; i < 8; i++) chk(ch(i), 16'h0100);
        wr(2'h0, 6'h01, 16'h0004);
        wr(2'h0, 6'h0b, 16'h0003);
        busy_len(16'h0018);
        wr(2'h3, 6'h09, 16'h5555);
        load_pulse();
        settle();
        chk(ch(1), 16'h5555);
        chk(ch(0), 16'h0100);
        wr(2'h0, 6'h01, 16'h0000);
        $display("test group and toggle done");
        data_format_select_in = 1'b1;
        cyc(3);
        wr(2'h3, 6'h0a, 16'hc000);
        load_pulse();
        settle();
        chk(ch(2), 16'h0000);
        data_format_select_in = 1'b0;
        peer_hold = 1'b1;
        wr(2'h3, 6'h0b, 16'h0777);
        load_pulse();
        cyc(70);
        chk(ch(3), 16'h0100);
        peer_hold = 1'b0;
        settle();
        chk(ch(3), 16'h0777);
        load_outputs_strobe_b_in = 1'b0;
        wr(2'h3, 6'h10, 16'h0abc);
        settle();
        chk(ch(4), 16'h0abc);
        load_outputs_strobe_b_in = 1'b1;
        $display("test format and busy line done");
        for (int i = 0; i < 10; i++) begin
            wr(2'h0, 6'h0a, 16'h0020 | 16'(i < 4 ? i : (i < 8 ? i + 4 : i + 8)));
            cyc(1);
            chk({6'h0, probe_route_out}, 16'(1 << i));
        end
        wr(2'h0, 6'h0a, 16'h0011);
        cyc(1);
        chk({5'h0, probe_output_oe_out, probe_route_out}, 16'h0000);
        wr(2'h0, 6'h0d, 16'h0003);
        cyc(3);
        chk({14'h0, gpio_oe_out, gpio_out}, 16'h0003);
        rd(6'h0d, 16'h0001);
        wr(2'h0, 6'h0d, 16'h0000);
        gpio_ext = 1'b0;
        cyc(3);
        chk({14'h0, gpio_oe_out, gpio_out}, 16'h0000);
        rd(6'h0d, 16'h0000);
        $display("test probe and pin done");
        wr(2'h0, 6'h01, 16'h0001);
        cyc(2);
        chk({15'h0, dac_off_out}, 16'h0001);
        chk(ch(0), 16'h0100);
        wr(2'h0, 6'h01, 16'h0002);
        cyc(2);
        chk({15'h0, dac_off_out}, 16'h0000);
        over_temp_in = 1'b1;
        cyc(5);
        chk({15'h0, dac_off_out}, 16'h0001);
        rd(6'h01, 16'h0012);
        over_temp_in = 1'b0;
        cyc(5);
        chk({15'h0, dac_off_out}, 16'h0001);
        wr(2'h0, 6'h01, 16'h0000);
        cyc(2);
        chk({15'h0, dac_off_out}, 16'h0000);
        $display("test shutdown done");
        stop_test();
    end
endmodule : duc_update_ctrl_tb_top
bind duc_update_ctrl duc_update_ctrl_checker duc_update_ctrl_checker_i (.*);
`default_nettype wire
